// ===== design/rhc_ctrl.sv
// operating state controller: system reset, normal run and halt, with reset register values
`timescale 1ns/10ps
`default_nettype none
`include "rhc_cfg.svh"

module rhc_ctrl #(
	parameter int N_PORTS          = 3,
	parameter int PINS_PER_PORT    = 4,
	parameter int N_SEG            = 31,
	parameter int N_TIMER          = 4,
	parameter int LCD_START_CYCLES = `RHC_LCD_START_CYC
) (
	input  wire logic                         core_clk,
	input  wire logic                         nrst,
	input  wire logic                         power_on_det,
	input  wire logic                         osc_stop_det,
	input  wire logic                         reset_pin_n,
	input  wire logic                         instr_first_cycle,
	input  wire logic                         pc_advance,
	input  wire logic                         pc_load,
	input  wire logic [11:0]                  pc_load_addr,
	input  wire logic                         irq_pending,
	input  wire logic                         irq_wake,
	input  wire logic                         lcd_off_mode,
	input  wire logic                         sfr_wr_en,
	input  wire rhc_pkg::rhc_sfr_t            sfr_wr_sel,
	input  wire logic [4:0]                   sfr_wr_idx,
	input  wire logic [7:0]                   sfr_wr_data,
	output var  rhc_pkg::rhc_state_t          op_state_r,
	output logic                              sys_reset_r,
	output logic                              cpu_halted_r,
	output logic                              periph_run_r,
	output logic                              halt_request_flag_r,
	output logic [11:0]                       pc_r,
	output logic [3:0]                        acc_a_r,
	output logic [3:0]                        acc_b_r,
	output logic                              carry_r,
	output logic [7:0]                        index_pair_primary_r,
	output logic [7:0]                        index_pair_secondary_r,
	output logic [7:0]                        stack_pointer_r,
	output logic [3:0]                        bank_select_primary_r,
	output logic [3:0]                        bank_select_secondary_r,
	output logic                              bank_common_flag_r,
	output logic                              bank_enable_flag_r,
	output logic [N_PORTS*4-1:0]              port_data_r,
	output logic [N_PORTS*PINS_PER_PORT*4-1:0] port_pin_control_r,
	output logic [3:0]                        port_pull_control_r,
	output logic [3:0]                        clock_source_control_r,
	output logic [3:0]                        buzzer_drive_control_r,
	output logic [3:0]                        buzzer_tone_control_r,
	output logic [3:0]                        display_duty_control_r,
	output logic [N_SEG*4-1:0]                display_segment_regs_r,
	output logic [N_TIMER*4-1:0]              timer_data_regs_r,
	output logic [N_TIMER*4-1:0]              timer_count_regs_r,
	output logic                              lcd_outputs_off_r,
	output logic                              lcd_drive_en_r
);
	import rhc_pkg::*;

	localparam int N_PINCTL = N_PORTS * PINS_PER_PORT;
	localparam int LCD_CW   = $clog2(LCD_START_CYCLES + 1);

	if (N_PINCTL > 32 || N_SEG > 32 || N_TIMER > 32 || N_PORTS > 32 || N_SEG < 1) begin : g_chk
		$error("rhc_ctrl: index fields are five bits wide");
	end
	if (LCD_START_CYCLES < 1) begin : g_chk_lcd
		$error("rhc_ctrl: lcd start delay must be at least one cycle");
	end

	// each reset source passes its own two flops before anything combines them;
	// the raw or-term is read by the checks only
	wire       rst_src_any = power_on_det | osc_stop_det | ~reset_pin_n;
	wire [2:0] rst_src_pin = {power_on_det, osc_stop_det, reset_pin_n};
	// pin level of each source while it asks for reset; flops leave nrst there
	localparam logic [2:0] RST_SRC_ACTIVE = 3'b110;
	logic [2:0] src_meta_r;
	logic [2:0] src_sync_r;

	for (genvar s = 0; s < 3; s++) begin : g_src_sync
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				src_meta_r[s] <= RST_SRC_ACTIVE[s];
				src_sync_r[s] <= RST_SRC_ACTIVE[s];
			end else begin
				src_meta_r[s] <= rst_src_pin[s];
				src_sync_r[s] <= src_meta_r[s];
			end
		end
	end

	// any synchronised source holds reset; release waits for the last one
	wire rst_sync_r = |(src_sync_r ~^ RST_SRC_ACTIVE);

	// state machine
	rhc_state_t state_nxt;
	wire halt_go   = halt_request_flag_r & instr_first_cycle & ~irq_pending;
	wire in_run    = (op_state_r == RHC_ST_RUN);
	wire in_halt   = (op_state_r == RHC_ST_HALT);
	wire wake      = in_halt & irq_wake;

	always_comb begin
		state_nxt = op_state_r;
		unique case (op_state_r)
			RHC_ST_RESET: state_nxt = RHC_ST_RUN;
			RHC_ST_RUN:   if (halt_go) state_nxt = RHC_ST_HALT;
			RHC_ST_HALT:  if (irq_wake) state_nxt = RHC_ST_RUN;
			default:      state_nxt = RHC_ST_RESET;
		endcase
		if (rst_sync_r)
			state_nxt = RHC_ST_RESET;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			op_state_r   <= RHC_ST_RESET;
			sys_reset_r  <= 1'b1;
			cpu_halted_r <= 1'b0;
			periph_run_r <= 1'b0;
		end else begin
			op_state_r   <= state_nxt;
			sys_reset_r  <= (state_nxt == RHC_ST_RESET);
			cpu_halted_r <= (state_nxt == RHC_ST_HALT);
			// peripherals see no difference between run and halt
			periph_run_r <= (state_nxt != RHC_ST_RESET);
		end
	end

	// halt request flag: software writes count only in run, so the wake cycle always clears it
	wire sel_halt = sfr_wr_en & in_run & (sfr_wr_sel == RHC_SFR_HALT);
	wire halt_set = sel_halt & sfr_wr_data[`RHC_HALT_BIT];
	wire halt_clr = (sel_halt & ~sfr_wr_data[`RHC_HALT_BIT]) | wake;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			halt_request_flag_r <= `RHC_BIT_ZERO;
		else if (rst_sync_r)
			halt_request_flag_r <= `RHC_BIT_ZERO;
		else if (halt_set)
			halt_request_flag_r <= 1'b1;
		else if (halt_clr)
			halt_request_flag_r <= `RHC_BIT_ZERO;
	end

	// program counter; frozen in halt so a halted fetch repeats the same address, loaded with the reset value in reset
	wire [11:0] pc_nxt = pc_load ? pc_load_addr : 12'(pc_r + 12'h001);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			pc_r <= `RHC_PC_RST;
		else if (rst_sync_r || op_state_r == RHC_ST_RESET)
			pc_r <= `RHC_PC_RST;
		else if (in_run && (pc_advance || pc_load))
			pc_r <= pc_nxt;
	end

	// register writes only happen while the core executes
	wire        wr_ok   = sfr_wr_en & in_run & ~rst_sync_r;
	wire [3:0]  wr_nib  = sfr_wr_data[3:0];
	wire        wr_bit  = sfr_wr_data[0];
	wire [7:0]  stk_wval = {1'b1, sfr_wr_data[6:1], 1'b1};
	function automatic logic hit(input rhc_sfr_t s);
		hit = wr_ok && (sfr_wr_sel == s);
	endfunction

	// core registers, all reset by system reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			acc_a_r                 <= `RHC_NIB_ZERO;
			acc_b_r                 <= `RHC_NIB_ZERO;
			carry_r                 <= `RHC_BIT_ZERO;
			index_pair_primary_r    <= `RHC_BYTE_ZERO;
			index_pair_secondary_r  <= `RHC_BYTE_ZERO;
			stack_pointer_r         <= `RHC_STK_RST;
			bank_select_primary_r   <= `RHC_NIB_ZERO;
			bank_select_secondary_r <= `RHC_NIB_ZERO;
			bank_common_flag_r      <= `RHC_BIT_ZERO;
			bank_enable_flag_r      <= `RHC_BIT_ZERO;
		end else if (rst_sync_r) begin
			acc_a_r                 <= `RHC_NIB_ZERO;
			acc_b_r                 <= `RHC_NIB_ZERO;
			carry_r                 <= `RHC_BIT_ZERO;
			index_pair_primary_r    <= `RHC_BYTE_ZERO;
			index_pair_secondary_r  <= `RHC_BYTE_ZERO;
			stack_pointer_r         <= `RHC_STK_RST;
			bank_select_primary_r   <= `RHC_NIB_ZERO;
			bank_select_secondary_r <= `RHC_NIB_ZERO;
			bank_common_flag_r      <= `RHC_BIT_ZERO;
			bank_enable_flag_r      <= `RHC_BIT_ZERO;
		end else begin
			if (hit(RHC_SFR_ACC_A))    acc_a_r                 <= wr_nib;
			if (hit(RHC_SFR_ACC_B))    acc_b_r                 <= wr_nib;
			if (hit(RHC_SFR_CARRY))    carry_r                 <= wr_bit;
			if (hit(RHC_SFR_IDX_PRI))  index_pair_primary_r    <= sfr_wr_data;
			if (hit(RHC_SFR_IDX_SEC))  index_pair_secondary_r  <= sfr_wr_data;
			// end bits of the stack pointer are fixed at one
			if (hit(RHC_SFR_STK))      stack_pointer_r         <= stk_wval;
			if (hit(RHC_SFR_BANK_PRI)) bank_select_primary_r   <= wr_nib;
			if (hit(RHC_SFR_BANK_SEC)) bank_select_secondary_r <= wr_nib;
			if (hit(RHC_SFR_BANK_CMN)) bank_common_flag_r      <= wr_bit;
			if (hit(RHC_SFR_BANK_EN))  bank_enable_flag_r      <= wr_bit;
		end
	end

	// peripheral control registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			port_pull_control_r    <= `RHC_PULL_RST;
			clock_source_control_r <= `RHC_CLKSRC_RST;
			buzzer_drive_control_r <= `RHC_NIB_ZERO;
			buzzer_tone_control_r  <= `RHC_BUZT_RST;
			display_duty_control_r <= `RHC_DISP_RST;
		end else if (rst_sync_r) begin
			port_pull_control_r    <= `RHC_PULL_RST;
			clock_source_control_r <= `RHC_CLKSRC_RST;
			buzzer_drive_control_r <= `RHC_NIB_ZERO;
			buzzer_tone_control_r  <= `RHC_BUZT_RST;
			display_duty_control_r <= `RHC_DISP_RST;
		end else begin
			if (hit(RHC_SFR_PULL))   port_pull_control_r    <= wr_nib;
			if (hit(RHC_SFR_CLKSRC)) clock_source_control_r <= wr_nib;
			if (hit(RHC_SFR_BUZD))   buzzer_drive_control_r <= wr_nib;
			if (hit(RHC_SFR_BUZT))   buzzer_tone_control_r  <= wr_nib;
			if (hit(RHC_SFR_DISP))   display_duty_control_r <= wr_nib;
		end
	end

	// indexed nibble registers; separate generates cover ports, pin controls, segments
	for (genvar i = 0; i < N_PORTS; i++) begin : g_port
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst)
				port_data_r[i*4 +: 4] <= `RHC_NIB_ZERO;
			else if (rst_sync_r)
				port_data_r[i*4 +: 4] <= `RHC_NIB_ZERO;
			else if (hit(RHC_SFR_PORT) && sfr_wr_idx == 5'(i))
				port_data_r[i*4 +: 4] <= wr_nib;
		end
	end

	for (genvar i = 0; i < N_PINCTL; i++) begin : g_pinctl
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst)
				port_pin_control_r[i*4 +: 4] <= `RHC_NIB_ZERO;
			else if (rst_sync_r)
				port_pin_control_r[i*4 +: 4] <= `RHC_NIB_ZERO;
			else if (hit(RHC_SFR_PINCTL) && sfr_wr_idx == 5'(i))
				port_pin_control_r[i*4 +: 4] <= wr_nib;
		end
	end

	for (genvar i = 0; i < N_SEG; i++) begin : g_seg
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst)
				display_segment_regs_r[i*4 +: 4] <= `RHC_NIB_ZERO;
			else if (rst_sync_r)
				display_segment_regs_r[i*4 +: 4] <= `RHC_NIB_ZERO;
			else if (hit(RHC_SFR_SEG) && sfr_wr_idx == 5'(i))
				display_segment_regs_r[i*4 +: 4] <= wr_nib;
		end
	end

	// timer data and count keep whatever they held; no reset by design, so
	// software must load them before trusting them
	for (genvar i = 0; i < N_TIMER; i++) begin : g_tmr
		always_ff @(posedge core_clk) begin
			if (hit(RHC_SFR_TMR_DATA) && sfr_wr_idx == 5'(i))
				timer_data_regs_r[i*4 +: 4] <= wr_nib;
			if (hit(RHC_SFR_TMR_CNT) && sfr_wr_idx == 5'(i))
				timer_count_regs_r[i*4 +: 4] <= wr_nib;
		end
	end

	// lcd start: outputs parked at supply during reset, waveforms after the delay.
	// oscillation start is taken as reset release since the clock is the oscillator
	logic [LCD_CW-1:0] lcd_cnt_r;
	wire               lcd_done = (lcd_cnt_r == LCD_CW'(LCD_START_CYCLES));

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lcd_cnt_r         <= '0;
			lcd_outputs_off_r <= 1'b1;
			lcd_drive_en_r    <= 1'b0;
		end else if (rst_sync_r) begin
			lcd_cnt_r         <= '0;
			lcd_outputs_off_r <= 1'b1;
			lcd_drive_en_r    <= 1'b0;
		end else begin
			if (!lcd_done)
				lcd_cnt_r <= LCD_CW'(lcd_cnt_r + 1'b1);
			lcd_drive_en_r    <= lcd_done & ~lcd_off_mode;
			lcd_outputs_off_r <= ~(lcd_done & ~lcd_off_mode);
		end
	end

	// checks
	sequence s_halt_cause;
		in_run && halt_request_flag_r && instr_first_cycle && !irq_pending && !rst_sync_r;
	endsequence
	sequence s_halt_entered;
		op_state_r == RHC_ST_HALT && cpu_halted_r;
	endsequence

	a_state_legal: assert property (@(posedge core_clk) disable iff (!nrst)
		op_state_r inside {RHC_ST_RESET, RHC_ST_RUN, RHC_ST_HALT})
		else $error("illegal operating state");
	a_reset_sources: assert property (@(posedge core_clk) disable iff (!nrst)
		rst_src_any |-> ##3 sys_reset_r)
		else $error("reset source did not force reset");
	a_reset_priority: assert property (@(posedge core_clk) disable iff (!nrst)
		rst_sync_r |=> op_state_r == RHC_ST_RESET)
		else $error("reset did not override state");
	a_reset_release: assert property (@(posedge core_clk) disable iff (!nrst)
		!rst_src_any [*3] |=> !sys_reset_r)
		else $error("reset held after all sources released");
	a_pc_start: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(sys_reset_r) |-> pc_r == `RHC_PC_RST)
		else $error("execution not starting at zero");
	a_pc_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		in_halt && !rst_sync_r |=> $stable(pc_r))
		else $error("program counter moved in halt");
	a_halt_entry: assert property (@(posedge core_clk) disable iff (!nrst)
		s_halt_cause |=> s_halt_entered)
		else $error("halt not entered");
	a_halt_irq_block: assert property (@(posedge core_clk) disable iff (!nrst)
		in_run && irq_pending |=> !in_halt)
		else $error("halt entered with interrupt pending");
	a_halt_wake: assert property (@(posedge core_clk) disable iff (!nrst)
		in_halt && irq_wake && !rst_sync_r && !halt_set |=> in_run && !halt_request_flag_r)
		else $error("halt not released by interrupt");
	a_halt_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
		halt_set && !rst_sync_r |=> halt_request_flag_r)
		else $error("halt flag not set by write");
	a_periph_halt: assert property (@(posedge core_clk) disable iff (!nrst)
		in_halt && !rst_sync_r |=> periph_run_r && $stable(port_data_r))
		else $error("peripherals disturbed in halt");
	a_sfr_reset: assert property (@(posedge core_clk) disable iff (!nrst)
		rst_sync_r |=> port_pull_control_r == `RHC_PULL_RST
			&& clock_source_control_r == `RHC_CLKSRC_RST
			&& display_duty_control_r == `RHC_DISP_RST
			&& stack_pointer_r == `RHC_STK_RST && port_data_r == '0)
		else $error("register reset values wrong");
	a_lcd_off_reset: assert property (@(posedge core_clk) disable iff (!nrst)
		sys_reset_r |-> lcd_outputs_off_r && !lcd_drive_en_r)
		else $error("lcd driven during reset");

endmodule : rhc_ctrl
`default_nettype wire

// ===== pkg/rhc_cfg.svh
// reset values, field positions and timing counts of the reset and halt controller
`ifndef RHC_CFG_SVH
`define RHC_CFG_SVH

`define RHC_PC_RST        12'h000
`define RHC_NIB_ZERO      4'h0
`define RHC_BYTE_ZERO     8'h00
`define RHC_STK_RST       8'hff
`define RHC_PULL_RST      4'he
`define RHC_CLKSRC_RST    4'he
`define RHC_BUZT_RST      4'he
`define RHC_DISP_RST      4'h8
`define RHC_BIT_ZERO      1'b0
`define RHC_HALT_BIT      0
`define RHC_STK_LSB       0
`define RHC_STK_MSB       7
`define RHC_LCD_START_MS  63
`define RHC_CLK_MHZ       200
`define RHC_LCD_START_CYC (`RHC_LCD_START_MS * 1000 * `RHC_CLK_MHZ)

`endif

// ===== pkg/rhc_pkg.sv
// types of the reset and halt controller
`default_nettype none

package rhc_pkg;

	typedef enum logic [1:0] {
		RHC_ST_RESET = 2'h0,
		RHC_ST_RUN   = 2'h1,
		RHC_ST_HALT  = 2'h3
	} rhc_state_t;

	typedef enum logic [4:0] {
		RHC_SFR_ACC_A    = 5'h00,
		RHC_SFR_ACC_B    = 5'h01,
		RHC_SFR_CARRY    = 5'h02,
		RHC_SFR_IDX_PRI  = 5'h03,
		RHC_SFR_IDX_SEC  = 5'h04,
		RHC_SFR_STK      = 5'h05,
		RHC_SFR_BANK_PRI = 5'h06,
		RHC_SFR_BANK_SEC = 5'h07,
		RHC_SFR_BANK_CMN = 5'h08,
		RHC_SFR_BANK_EN  = 5'h09,
		RHC_SFR_PORT     = 5'h0a,
		RHC_SFR_PINCTL   = 5'h0b,
		RHC_SFR_PULL     = 5'h0c,
		RHC_SFR_CLKSRC   = 5'h0d,
		RHC_SFR_BUZD     = 5'h0e,
		RHC_SFR_BUZT     = 5'h0f,
		RHC_SFR_DISP     = 5'h10,
		RHC_SFR_SEG      = 5'h11,
		RHC_SFR_TMR_DATA = 5'h12,
		RHC_SFR_TMR_CNT  = 5'h13,
		RHC_SFR_HALT     = 5'h14
	} rhc_sfr_t;

endpackage : rhc_pkg

`default_nettype wire

// ===== test/rhc_cpu_model.sv
// cpu core model: instruction fetch strobes and program counter step requests
`timescale 1ns/10ps
`default_nettype none

module rhc_cpu_model (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic run_en,
	output logic      instr_first_cycle,
	output logic      pc_advance
);
	logic phase_r;

	initial begin
		phase_r = 1'b0;
		instr_first_cycle = 1'b0;
		pc_advance = 1'b0;
	end

	// two-cycle instructions; fetching goes on in halt, gating the step is the block's job
	always @(posedge core_clk) begin
		#1;
		if (!nrst || !run_en) begin
			phase_r = 1'b0;
			instr_first_cycle = 1'b0;
			pc_advance = 1'b0;
		end else begin
			phase_r = ~phase_r;
			instr_first_cycle = phase_r;
			pc_advance = phase_r;
		end
	end
endmodule : rhc_cpu_model

`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench of the reset and halt controller
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import rhc_pkg::*;
	// short display start count keeps the run brief
	localparam int LCD_CYC = 20;
	logic core_clk, nrst, power_on_det, osc_stop_det, reset_pin_n, run_en;
	logic instr_first_cycle, pc_advance, pc_load, irq_pending, irq_wake, lcd_off_mode, sfr_wr_en;
	logic [11:0] pc_load_addr, pc_r, port_data_r;
	rhc_sfr_t sfr_wr_sel;
	logic [4:0] sfr_wr_idx;
	logic [7:0] sfr_wr_data, index_pair_primary_r, index_pair_secondary_r, stack_pointer_r;
	rhc_state_t op_state_r;
	logic sys_reset_r, cpu_halted_r, periph_run_r, halt_request_flag_r, carry_r;
	logic bank_common_flag_r, bank_enable_flag_r, lcd_outputs_off_r, lcd_drive_en_r;
	logic [3:0] acc_a_r, acc_b_r, bank_select_primary_r, bank_select_secondary_r;
	logic [3:0] port_pull_control_r, clock_source_control_r, buzzer_drive_control_r;
	logic [3:0] buzzer_tone_control_r, display_duty_control_r;
	logic [47:0] port_pin_control_r;
	logic [123:0] display_segment_regs_r;
	logic [15:0] timer_data_regs_r, timer_count_regs_r;
	int errors;
	int checked;

	rhc_ctrl #(.LCD_START_CYCLES(LCD_CYC)) rhc_ctrl_inst (.*);
	rhc_cpu_model rhc_cpu_model_inst (.core_clk(core_clk), .nrst(nrst), .run_en(run_en),
		.instr_first_cycle(instr_first_cycle), .pc_advance(pc_advance));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic results();
		if (errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	task automatic step(input int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step

	task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	task automatic chk_st(input rhc_state_t s);
		chk("op_state", s, op_state_r);
		chk("sys_reset", s == RHC_ST_RESET, sys_reset_r);
		chk("cpu_halted", s == RHC_ST_HALT, cpu_halted_r);
		chk("periph_run", s != RHC_ST_RESET, periph_run_r);
	endtask : chk_st

	// bounded wait, then the full state picture is judged
	task automatic wait_st(input rhc_state_t s, input int n);
		int i;
		i = 0;
		while (op_state_r !== s && i < n) begin
			step();
			i++;
		end
		chk_st(s);
	endtask : wait_st

	task automatic wr(input rhc_sfr_t sel, input logic [4:0] idx, input logic [7:0] d);
		sfr_wr_sel = sel;
		sfr_wr_idx = idx;
		sfr_wr_data = d;
		sfr_wr_en = 1'b1;
		step();
		// an idle edge between writes keeps the strobe from toggling twice in one step
		sfr_wr_en = 1'b0;
		step();
	endtask : wr

	task automatic src(input int k, input logic v);
		if (k == 0) power_on_det = v;
		else if (k == 1) osc_stop_det = v;
		else reset_pin_n = ~v;
	endtask : src

	task automatic chk_rst();
		chk("pc", 12'h000, pc_r);
		chk("acc_a", 4'h0, acc_a_r);
		chk("acc_b", 4'h0, acc_b_r);
		chk("carry", 1'b0, carry_r);
		chk("index_pri", 8'h00, index_pair_primary_r);
		chk("index_sec", 8'h00, index_pair_secondary_r);
		chk("stack_ptr", 8'hff, stack_pointer_r);
		chk("bank_pri", 4'h0, bank_select_primary_r);
		chk("bank_sec", 4'h0, bank_select_secondary_r);
		chk("bank_common", 1'b0, bank_common_flag_r);
		chk("bank_enable", 1'b0, bank_enable_flag_r);
		chk("port_data", 12'h000, port_data_r);
		chk("pin_ctl", 48'h0, port_pin_control_r);
		chk("pull_ctl", 4'he, port_pull_control_r);
		chk("clk_src", 4'he, clock_source_control_r);
		chk("buz_drive", 4'h0, buzzer_drive_control_r);
		chk("buz_tone", 4'he, buzzer_tone_control_r);
		chk("disp_duty", 4'h8, display_duty_control_r);
		chk("segments", 124'h0, display_segment_regs_r);
		chk("halt_flag", 1'b0, halt_request_flag_r);
		chk("lcd_off", 1'b1, lcd_outputs_off_r);
		chk("lcd_drive", 1'b0, lcd_drive_en_r);
	endtask : chk_rst

	task automatic wait_rst(input int n);
		int i;
		i = 0;
		while (sys_reset_r !== 1'b1 && i < n) begin
			step();
			i++;
		end
		chk_st(RHC_ST_RESET);
	endtask : wait_rst

	// dirty every register but the halt flag (index 1 of the indexed ones, index 2 for the timer count), then a pin reset must reload all but the timers
	task automatic t_writes();
		for (int i = 0; i <= 17; i++) wr(rhc_sfr_t'(i), 5'h01, 8'h35);
		wr(RHC_SFR_TMR_DATA, 5'h01, 8'h07);
		wr(RHC_SFR_TMR_CNT, 5'h02, 8'h0c);
		chk("stack_ptr", 8'hb5, stack_pointer_r);
		chk("acc_a", 4'h5, acc_a_r);
		chk("port_data", 12'h050, port_data_r);
		chk("pin_ctl", 4'h5, port_pin_control_r[7:4]);
		chk("segments", 4'h5, display_segment_regs_r[7:4]);
		chk("buz_drive", 4'h5, buzzer_drive_control_r);
		src(2, 1'b1);
		wait_rst(4);
		chk_rst();
		chk("timer_data", 4'h7, timer_data_regs_r[7:4]);
		chk("timer_count", 4'hc, timer_count_regs_r[11:8]);
		src(2, 1'b0);
		wait_st(RHC_ST_RUN, 6);
	endtask : t_writes

	task automatic t_sources();
		for (int k = 0; k < 3; k++) begin
			src(k, 1'b1);
			wait_rst(4);
			src(k, 1'b0);
			wait_st(RHC_ST_RUN, 6);
		end
		src(0, 1'b1);
		src(2, 1'b1);
		step(4);
		src(0, 1'b0);
		step(6);
		chk_st(RHC_ST_RESET);
		src(2, 1'b0);
		wait_st(RHC_ST_RUN, 6);
	endtask : t_sources

	task automatic t_halt();
		logic [11:0] p;
		logic [11:0] q;
		pc_load_addr = 12'h5a3;
		pc_load = 1'b1;
		step();
		pc_load = 1'b0;
		chk("pc_load", 12'h5a3, pc_r);
		irq_pending = 1'b1;
		wr(RHC_SFR_HALT, 5'h00, 8'h01);
		chk("halt_flag", 1'b1, halt_request_flag_r);
		step(6);
		chk_st(RHC_ST_RUN);
		irq_pending = 1'b0;
		wait_st(RHC_ST_HALT, 4);
		p = pc_r;
		q = port_data_r;
		step(8);
		chk("pc_hold", p, pc_r);
		wr(RHC_SFR_ACC_A, 5'h00, 8'h0a);
		chk("acc_a", 4'h0, acc_a_r);
		chk("port_data", q, port_data_r);
		irq_wake = 1'b1;
		step();
		irq_wake = 1'b0;
		chk_st(RHC_ST_RUN);
		chk("halt_flag", 1'b0, halt_request_flag_r);
		p = pc_r;
		step(2);
		chk("pc_step", p + 12'h001, pc_r);
		wr(RHC_SFR_HALT, 5'h00, 8'h01);
		wait_st(RHC_ST_HALT, 4);
		src(1, 1'b1);
		wait_rst(4);
		chk("halt_flag", 1'b0, halt_request_flag_r);
		chk("pc", 12'h000, pc_r);
		src(1, 1'b0);
		wait_st(RHC_ST_RUN, 6);
	endtask : t_halt

	task automatic t_lcd(input logic off_mode);
		int i;
		lcd_off_mode = off_mode;
		nrst = 1'b0;
		step(2);
		chk_rst();
		nrst = 1'b1;
		wait_st(RHC_ST_RUN, 6);
		step(15);
		chk("lcd_drive", 1'b0, lcd_drive_en_r);
		i = 0;
		while (lcd_drive_en_r !== 1'b1 && i < 20) begin
			step();
			i++;
		end
		chk("lcd_drive", !off_mode, lcd_drive_en_r);
		chk("lcd_off", off_mode, lcd_outputs_off_r);
	endtask : t_lcd

	initial begin
		errors = 0;
		checked = 0;
		{nrst, power_on_det, osc_stop_det, pc_load, irq_pending, irq_wake} = 6'h00;
		{lcd_off_mode, sfr_wr_en, pc_load_addr, sfr_wr_idx, sfr_wr_data} = 27'h0;
		sfr_wr_sel = RHC_SFR_ACC_A;
		reset_pin_n = 1'b1;
		run_en = 1'b1;
		step(16);
		nrst = 1'b1;
		chk_rst();
		wait_st(RHC_ST_RUN, 6);
		t_writes();
		t_sources();
		t_halt();
		t_lcd(1'b0);
		t_lcd(1'b1);
		results();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		errors++;
		results();
	end
endmodule : tb_top

`default_nettype wire
